/* File: e1r_line_model.sv */
// line interface and backplane clock sources facing the receive block
`timescale 1ns/1ps
module e1r_line_model
  import e1r_pkg::*;
(
  input  wire logic nrz,
  input  wire logic viol,
  input  wire logic tx_stop,
  input  wire logic sys_on,
  output logic      line_clk,
  output logic      pos,
  output logic      neg,
  output logic      sys_clk,
  output logic      ref_clk,
  output logic      tx_clk,
  output logic      sync_in
);
  logic [7:0] bit_idx = 8'h0;
  logic [3:0] frm = 4'h0;
  logic [7:0] sys_cnt = 8'h0;
  logic [7:0] octet;
  logic       mark_neg = 1'b0;
  logic       b;
  initial begin
    line_clk = 1'b0;
    sys_clk = 1'b0;
    ref_clk = 1'b0;
    tx_clk = 1'b0;
    pos = 1'b0;
    neg = 1'b0;
    sync_in = 1'b0;
  end
  always #40 line_clk = ~line_clk;
  always #244 ref_clk = ~ref_clk;
  // stoppable so the loss detector can be exercised
  always #244 if (!tx_stop) tx_clk = ~tx_clk;
  // held low unless the elastic store is in use
  always #244 sys_clk = sys_on ? ~sys_clk : 1'b0;
  // bit changes after the rise, steady over the falling sample edge
  always @(posedge line_clk) begin
    octet = (bit_idx[7:3] != 5'h0) ? {bit_idx[7:3], 3'h5} : frm[0] ? 8'h40 : {1'b1, E1R_FAS_WORD};
    b = octet[3'h7 - bit_idx[2:0]];
    pos <= b && (nrz || !mark_neg);
    neg <= b && (nrz || mark_neg);
    // viol repeats a polarity on purpose
    if (b && !viol) mark_neg <= !mark_neg;
    bit_idx <= bit_idx + 8'h1;
    if (bit_idx == 8'hff) frm <= frm + 4'h1;
  end
  // frame boundary pulse timed to the system clock
  always @(posedge sys_clk) begin
    sys_cnt <= sys_cnt + 8'h1;
    sync_in <= (sys_cnt == 8'hff);
  end
endmodule : e1r_line_model

/* File: e1r_pkg.sv */
// constants and types for the e1 receive backplane interface
// Contract
// R1: link data follows recovered stream each line-clock rise
// R2: link clock between 4 and 20 kHz
// R3: line side supplies 2.048 MHz line clock (the line model drives 12.5 MHz, an 80 ns period)
// R4: legacy channel clock high during channel LSB
// R5: channel block level programmed per channel
// R6: serial out retimed by line or system clock
// R7: sync output marks frame or multiframe, one period
// R8: sync input accepted only with elastic store
// R9: frame pulse marks every frame boundary
// R10: legacy multiframe pulse on selected clock
// R11: backplane supplies system clock for elastic store
// R12: enhanced mode signaling stream in PCM format
// R13: legacy loss output: search or tx clock stopped
// R14: enhanced mode 8.192 MHz synthesized clock
// R15: line inputs sampled on line-clock falling edge
// R16: NRZ mode disables bipolar violation monitoring
// R17: strap low enhanced, high legacy
// R18: 32 timeslots per frame, MSB first
// R19: sync pin defaults to output after reset
package e1r_pkg;
  localparam int          E1R_CLK_PERIOD_PS = 5000;
  localparam int          E1R_TXCLK_LOSS_NS = 5000;
  localparam int          E1R_TXCLK_LOSS_CYC = (E1R_TXCLK_LOSS_NS * 1000) / E1R_CLK_PERIOD_PS;
  localparam int          E1R_SLOTS = 32;
  localparam int          E1R_FRAMES_PER_MF = 16;
  localparam int          E1R_SIG_SLOT = 16;
  localparam int          E1R_SYNTH_MULT = 4;
  localparam logic [6:0]  E1R_FAS_WORD = 7'h1b;
  // synchroniser slots for pin inputs
  localparam int          E1R_PIN_LINE_CLK = 0;
  localparam int          E1R_PIN_POS = 1;
  localparam int          E1R_PIN_NEG = 2;
  localparam int          E1R_PIN_SYS_CLK = 3;
  localparam int          E1R_PIN_SYNC_IN = 4;
  localparam int          E1R_PIN_STRAP = 5;
  localparam int          E1R_PIN_TX_CLK = 6;
  localparam int          E1R_PIN_REF_CLK = 7;
  localparam int          E1R_PIN_COUNT = 8;
  // register byte addresses
  localparam logic [3:0]  E1R_ADDR_CTRL = 4'h0;
  localparam logic [3:0]  E1R_ADDR_BLOCK = 4'h4;
  localparam logic [3:0]  E1R_ADDR_STATUS = 4'h8;
  localparam logic [3:0]  E1R_ADDR_BPV = 4'hc;
  localparam logic [4:0]  E1R_CTRL_RESET = 5'h00;
  localparam logic [31:0] E1R_BLOCK_RESET = 32'h0000_0000;

  typedef struct packed {
    logic nrz_mode;
    logic loss_output_select;
    logic sync_in_en;
    logic sync_mf_sel;
    logic es_en;
  } e1r_ctrl_s;

  typedef struct packed {
    logic tx_clk_lost;
    logic loss_out;
    logic legacy;
    logic locked;
  } e1r_status_s;

  typedef enum logic [0:0] {
    E1R_SEARCH = 1'b0,
    E1R_LOCKED = 1'b1
  } e1r_sync_e;
endpackage : e1r_pkg

/* File: e1r_rx_backplane.sv */
// e1 receive pin logic: line sampling, framing, retiming, backplane outputs
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module e1r_rx_backplane
  import e1r_pkg::*;
#(
  parameter int BPV_WIDTH = 16
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_line_clock,
  input  wire logic        rx_positive_in,
  input  wire logic        rx_negative_in,
  input  wire logic        rx_system_clock,
  input  wire logic        framer_mode_strap,
  input  wire logic        tx_line_clock,
  input  wire logic        synth_reference_clock,
  input  wire logic        rx_boundary_sync_in,
  output logic             rx_boundary_sync_out,
  output logic             rx_boundary_sync_oe,
  output logic             receive_link_data,
  output logic             receive_link_clock,
  output logic             rx_channel_clock,
  output logic             rx_channel_block,
  output logic             rx_serial_out,
  output logic             rx_frame_pulse,
  output logic             rx_multiframe_pulse,
  output logic             rx_signaling_out,
  output logic             loss_sync_or_tx_clock,
  output logic             synth_output_clock
);

  // pin synchronisers: stage 1 feeds stage 2 only
  logic [E1R_PIN_COUNT-1:0] pins;
  logic [E1R_PIN_COUNT-1:0] sync1_reg;
  logic [E1R_PIN_COUNT-1:0] sync2_reg;
  logic [E1R_PIN_COUNT-1:0] sync3_reg;

  assign pins = {synth_reference_clock, tx_line_clock, framer_mode_strap, rx_boundary_sync_in,
                 rx_system_clock, rx_negative_in, rx_positive_in, rx_line_clock};

  genvar gi;
  generate
    for (gi = 0; gi < E1R_PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  logic line_rise;
  logic line_fall;
  logic sys_rise;
  logic tx_edge;
  logic ref_rise;
  logic sync_in_rise;
  assign line_rise    = sync2_reg[E1R_PIN_LINE_CLK] & ~sync3_reg[E1R_PIN_LINE_CLK];
  assign line_fall    = ~sync2_reg[E1R_PIN_LINE_CLK] & sync3_reg[E1R_PIN_LINE_CLK];
  assign sys_rise     = sync2_reg[E1R_PIN_SYS_CLK] & ~sync3_reg[E1R_PIN_SYS_CLK];
  assign tx_edge      = sync2_reg[E1R_PIN_TX_CLK] ^ sync3_reg[E1R_PIN_TX_CLK];
  assign ref_rise     = sync2_reg[E1R_PIN_REF_CLK] & ~sync3_reg[E1R_PIN_REF_CLK];
  assign sync_in_rise = sync2_reg[E1R_PIN_SYNC_IN] & ~sync3_reg[E1R_PIN_SYNC_IN];

  // registers
  e1r_ctrl_s             ctrl_reg;
  logic [31:0]           block_reg;
  logic [BPV_WIDTH-1:0]  bpv_reg;
  logic                  ack_reg;
  logic                  legacy_reg;
  e1r_status_s           status;
  logic                  es_on;

  // R17 strap low enhanced, high legacy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      legacy_reg <= 1'b0;
    end else begin
      legacy_reg <= sync2_reg[E1R_PIN_STRAP];
    end
  end

  // R8 input mode only with elastic store
  assign es_on = ctrl_reg.es_en;

  // single wait state: every access answered on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg  <= E1R_CTRL_RESET;
      block_reg <= E1R_BLOCK_RESET;
    end else if (avs_write & ~avs_waitrequest) begin
      case (avs_address)
        E1R_ADDR_CTRL:  ctrl_reg  <= avs_writedata[4:0];
        E1R_ADDR_BLOCK: block_reg <= avs_writedata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    // loaded in the wait cycle so data already stand at the accepting edge
    end else if (avs_read & avs_waitrequest) begin
      case (avs_address)
        E1R_ADDR_CTRL:   avs_readdata <= {27'h0, ctrl_reg};
        E1R_ADDR_BLOCK:  avs_readdata <= block_reg;
        E1R_ADDR_STATUS: avs_readdata <= {28'h0, status};
        E1R_ADDR_BPV:    avs_readdata <= 32'(bpv_reg);
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // R15 sample both rails on the line-clock fall
  logic pos_reg;
  logic neg_reg;
  logic last_mark_neg_reg;
  logic rx_bit;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (line_fall) begin
      pos_reg <= sync2_reg[E1R_PIN_POS];
      neg_reg <= sync2_reg[E1R_PIN_NEG];
    end
  end

  // R16 tied rails: take one rail, skip violation counting
  assign rx_bit = ctrl_reg.nrz_mode ? pos_reg : (pos_reg | neg_reg);

  // violation: two marks of the same polarity in a row
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bpv_reg           <= '0;
      last_mark_neg_reg <= 1'b0;
    end else if (line_rise & ~ctrl_reg.nrz_mode & (pos_reg ^ neg_reg)) begin
      last_mark_neg_reg <= neg_reg;
      if ((neg_reg == last_mark_neg_reg) && (bpv_reg != '1)) begin
        bpv_reg <= bpv_reg + 1'b1;
      end
    end
  end

  // R18 frame counters, timeslot 0 first, MSB first
  e1r_sync_e  sync_state;
  logic [7:0] bit_cnt;
  logic [3:0] frame_cnt;
  logic [6:0] shift_reg;
  logic       fas_hit;
  assign fas_hit = ({shift_reg[5:0], rx_bit} == E1R_FAS_WORD);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_state <= E1R_SEARCH;
      bit_cnt    <= 8'h00;
      frame_cnt  <= 4'h0;
      shift_reg  <= 7'h00;
    end else if (line_rise) begin
      shift_reg <= {shift_reg[5:0], rx_bit};
      bit_cnt   <= bit_cnt + 8'h01;
      if (bit_cnt == 8'hff) begin
        frame_cnt <= frame_cnt + 4'h1;
      end
      case (sync_state)
        E1R_SEARCH: begin
          if (fas_hit) begin
            sync_state <= E1R_LOCKED;
            bit_cnt    <= 8'h08;
            frame_cnt  <= 4'h0;
          end
        end
        E1R_LOCKED: begin
          if ((bit_cnt == 8'h07) && !frame_cnt[0] && !fas_hit) begin
            sync_state <= E1R_SEARCH;
          end
        end
        default: sync_state <= E1R_SEARCH;
      endcase
    end
  end

  // R1 full recovered stream on every line-clock rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      receive_link_data <= 1'b0;
    end else if (line_rise) begin
      receive_link_data <= rx_bit;
    end
  end

  // R2 one full cycle per two frames gives 4 kHz
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      receive_link_clock <= 1'b0;
    end else begin
      receive_link_clock <= frame_cnt[0];
    end
  end

  // signaling nibbles gathered from timeslot 16 across the multiframe
  logic [3:0] sig_mem [E1R_SLOTS];
  always_ff @(posedge clk) begin
    if (line_rise && (sync_state == E1R_LOCKED) && (bit_cnt[7:3] == 5'(E1R_SIG_SLOT))
        && (bit_cnt[2:0] == 3'h7) && (frame_cnt != 4'h0)) begin
      sig_mem[{1'b0, frame_cnt}]   <= shift_reg[6:3];
      sig_mem[{1'b1, frame_cnt}]   <= {shift_reg[2:0], rx_bit};
    end
  end

  // elastic store: two frames, written on line timing, read on system timing
  logic       es_mem [512];
  logic [7:0] rd_cnt;
  logic [3:0] rd_frame;
  always_ff @(posedge clk) begin
    if (line_rise) begin
      es_mem[{frame_cnt[0], bit_cnt}] <= rx_bit;
    end
  end

  // R8 backplane pulse realigns the read side
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_cnt   <= 8'h00;
      rd_frame <= 4'h0;
    end else if (ctrl_reg.sync_in_en & es_on & sync_in_rise) begin
      rd_cnt   <= 8'h00;
      rd_frame <= 4'h0;
    end else if (sys_rise) begin
      rd_cnt <= rd_cnt + 8'h01;
      if (rd_cnt == 8'hff) begin
        rd_frame <= rd_frame + 4'h1;
      end
    end
  end

  // R11 system clock only steers timing with the store on
  logic       tick;
  logic [7:0] pos;
  logic [3:0] fr;
  assign tick = es_on ? sys_rise : line_rise;
  assign pos  = es_on ? rd_cnt : bit_cnt;
  assign fr   = es_on ? rd_frame : frame_cnt;

  logic [3:0] sig_nib;
  logic       sig_bit;
  assign sig_nib = sig_mem[pos[7:3]];
  assign sig_bit = pos[2] ? sig_nib[3 - pos[1:0]] : 1'b0;

  // R6 serial data retimed on the active clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_serial_out <= 1'b0;
    end else if (tick) begin
      rx_serial_out <= es_on ? es_mem[{rd_frame[0], rd_cnt}] : rx_bit;
    end
  end

  // backplane outputs per tick: strobes one timing period wide, block level held per channel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_channel_clock     <= 1'b0;
      rx_channel_block     <= 1'b0;
      rx_frame_pulse       <= 1'b0;
      rx_multiframe_pulse  <= 1'b0;
      rx_boundary_sync_out <= 1'b0;
      rx_signaling_out     <= 1'b0;
    end else if (tick) begin
      // R4 channel clock high during LSB, legacy only
      rx_channel_clock     <= legacy_reg & (pos[2:0] == 3'h7);
      // R5 per-channel programmed level
      rx_channel_block     <= block_reg[pos[7:3]];
      // R9 frame boundary pulse
      rx_frame_pulse       <= (pos == 8'h00);
      // R10 multiframe pulse, legacy only
      rx_multiframe_pulse  <= legacy_reg & (pos == 8'h00) & (fr == 4'h0);
      // R7 frame or multiframe boundary as selected
      rx_boundary_sync_out <= (pos == 8'h00) & (~ctrl_reg.sync_mf_sel | (fr == 4'h0));
      // R12 signaling nibble in low half of each channel
      rx_signaling_out     <= ~legacy_reg & sig_bit;
    end
  end

  // R19 output direction unless input mode with store enabled
  assign rx_boundary_sync_oe = ~(ctrl_reg.sync_in_en & es_on);

  // R13 watch for a stopped transmit clock
  logic [$clog2(E1R_TXCLK_LOSS_CYC+1)-1:0] tx_idle_cnt;
  logic                                    tx_lost;
  assign tx_lost = (tx_idle_cnt == ($bits(tx_idle_cnt))'(E1R_TXCLK_LOSS_CYC));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_idle_cnt <= '0;
    end else if (tx_edge) begin
      tx_idle_cnt <= '0;
    end else if (!tx_lost) begin
      tx_idle_cnt <= tx_idle_cnt + 1'b1;
    end
  end

  // R13 legacy only, source picked by control bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loss_sync_or_tx_clock <= 1'b0;
    end else begin
      loss_sync_or_tx_clock <= legacy_reg & (ctrl_reg.loss_output_select ? tx_lost
                                                           : (sync_state == E1R_SEARCH));
    end
  end

  assign status = '{tx_clk_lost: tx_lost, loss_out: loss_sync_or_tx_clock,
                    legacy: legacy_reg, locked: (sync_state == E1R_LOCKED)};

  // R14 period of reference measured, split in eight half cycles
  // jitter of one system clock is the price of a single-clock synth
  logic [7:0] ref_period;
  logic [7:0] ref_cnt;
  logic [4:0] half_cnt;
  logic [3:0] toggles;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_period         <= 8'h00;
      ref_cnt            <= 8'h00;
      half_cnt           <= 5'h00;
      toggles            <= 4'h0;
      synth_output_clock <= 1'b0;
    end else if (legacy_reg) begin
      synth_output_clock <= 1'b0;
      toggles            <= 4'h0;
    end else if (ref_rise) begin
      ref_period         <= ref_cnt;
      ref_cnt            <= 8'h00;
      half_cnt           <= 5'h00;
      toggles            <= 4'h1;
      synth_output_clock <= 1'b1;
    end else begin
      if (ref_cnt != 8'hff) begin
        ref_cnt <= ref_cnt + 8'h01;
      end
      if ((toggles != 4'(2 * E1R_SYNTH_MULT)) && (ref_period != 8'h00)) begin
        if (half_cnt >= ref_period[7:3]) begin
          half_cnt           <= 5'h00;
          toggles            <= toggles + 4'h1;
          synth_output_clock <= ~synth_output_clock;
        end else begin
          half_cnt <= half_cnt + 5'h01;
        end
      end
    end
  end

endmodule : e1r_rx_backplane

/* File: e1r_rx_backplane_tb_top.sv */
// self-checking bench for the e1 receive pin block
`timescale 1ns/1ps
module e1r_rx_backplane_tb_top
  import e1r_pkg::*;
  ;
  logic clk, reset, avs_read, avs_write, framer_mode_strap, nrz, viol, tx_stop, sys_on;
  logic avs_waitrequest, rx_line_clock, rx_positive_in, rx_negative_in, rx_system_clock;
  logic tx_line_clock, synth_reference_clock, rx_boundary_sync_in, rx_boundary_sync_out;
  logic rx_boundary_sync_oe, receive_link_data, receive_link_clock, rx_channel_clock;
  logic rx_channel_block, rx_serial_out, rx_frame_pulse, rx_multiframe_pulse;
  logic rx_signaling_out, loss_sync_or_tx_clock, synth_output_clock;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, rdata, bpv0;
  logic [255:0] ser_bits, link_bits, blk_bits;
  logic [67:0]  rows [4];
  int           fail_count = 0;
  int           n_checks = 0;
  int           k;

  e1r_rx_backplane dut_u (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .rx_line_clock, .rx_positive_in, .rx_negative_in, .rx_system_clock,
    .framer_mode_strap, .tx_line_clock, .synth_reference_clock, .rx_boundary_sync_in,
    .rx_boundary_sync_out, .rx_boundary_sync_oe, .receive_link_data, .receive_link_clock,
    .rx_channel_clock, .rx_channel_block, .rx_serial_out, .rx_frame_pulse,
    .rx_multiframe_pulse, .rx_signaling_out, .loss_sync_or_tx_clock, .synth_output_clock
  );
  e1r_line_model line_u (
    .nrz, .viol, .tx_stop, .sys_on, .line_clk(rx_line_clock), .pos(rx_positive_in),
    .neg(rx_negative_in), .sys_clk(rx_system_clock), .ref_clk(synth_reference_clock),
    .tx_clk(tx_line_clock), .sync_in(rx_boundary_sync_in)
  );

  always #2.5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic limit(input logic hit);
    if (hit) begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      conclude();
    end
  endtask : limit

  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    limit(n >= 40);
  endtask : bus

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask : rd_chk

  task automatic wait_lock;
    int n;
    rdata = 32'h0;
    for (n = 0; n < 60 && rdata[0] !== 1'b1; n++) begin
      repeat (1000) @(posedge clk);
      bus(1'b0, E1R_ADDR_STATUS, 32'h0);
    end
    limit(n >= 60);
  endtask : wait_lock

  task automatic count_rises(input int cycles, ref logic sig, output int n);
    logic prev;
    n = 0;
    prev = sig;
    repeat (cycles) begin
      @(posedge clk);
      if (sig === 1'b1 && prev !== 1'b1) n++;
      prev = sig;
    end
  endtask : count_rises

  // samples mid-bit from the frame pulse on; slot s lands in bits 255-8s down
  task automatic check_frame(input logic [31:0] blk);
    int n;
    for (n = 0; n < 9000 && rx_frame_pulse !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 9000 && rx_frame_pulse !== 1'b1; n++) @(posedge clk);
    limit(n >= 9000);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 256; i++) begin
      ser_bits[255 - i] = rx_serial_out;
      link_bits[255 - i] = receive_link_data;
      blk_bits[255 - i] = rx_channel_block;
      repeat (16) @(posedge clk);
    end
    for (int s = 1; s < 32; s++) begin
      check(ser_bits[255 - 8 * s -: 8], {s[4:0], 3'h5});
      check(link_bits[255 - 8 * s -: 8], {s[4:0], 3'h5});
      check(blk_bits[252 - 8 * s], blk[s]);
    end
  endtask : check_frame

  initial begin
    #495000;
    limit(1'b1);
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    framer_mode_strap = 1'b0;
    nrz = 1'b0;
    viol = 1'b0;
    tx_stop = 1'b0;
    sys_on = 1'b0;
    rows[0] = {E1R_ADDR_BLOCK, 32'h8000_0001, 32'h8000_0001};
    rows[1] = {4'h1, 32'hffff_ffff, 32'h0};
    rows[2] = {E1R_ADDR_STATUS, 32'hf, 32'h1};
    rows[3] = {E1R_ADDR_CTRL, 32'h0, 32'h0};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(rx_boundary_sync_oe, 1'b1);
    rd_chk(E1R_ADDR_CTRL, {27'h0, E1R_CTRL_RESET});
    rd_chk(E1R_ADDR_BLOCK, E1R_BLOCK_RESET);
    wait_lock();
    foreach (rows[i]) begin
      bus(1'b1, rows[i][67:64], rows[i][63:32]);
      rd_chk(rows[i][67:64], rows[i][31:0]);
    end
    check_frame(32'h8000_0001);
    bus(1'b0, E1R_ADDR_BPV, 32'h0);
    bpv0 = rdata;
    viol <= 1'b1;
    repeat (2000) @(posedge clk);
    viol <= 1'b0;
    bus(1'b0, E1R_ADDR_BPV, 32'h0);
    check(rdata > bpv0, 1'b1);
    // rails tied before the mode bit, so no bit is lost in between
    nrz <= 1'b1;
    repeat (40) @(posedge clk);
    bus(1'b1, E1R_ADDR_CTRL, 32'h10);
    bus(1'b0, E1R_ADDR_BPV, 32'h0);
    bpv0 = rdata;
    repeat (2000) @(posedge clk);
    rd_chk(E1R_ADDR_BPV, bpv0);
    check_frame(32'h8000_0001);
    bus(1'b1, E1R_ADDR_CTRL, 32'h0);
    nrz <= 1'b0;
    framer_mode_strap <= 1'b1;
    repeat (20) @(posedge clk);
    rd_chk(E1R_ADDR_STATUS, 32'h3);
    count_rises(4096, rx_channel_clock, k);
    check(k, 32);
    for (k = 0; k < 70000 && rx_multiframe_pulse !== 1'b1; k++) @(posedge clk);
    limit(k >= 70000);
    check(rx_frame_pulse, 1'b1);
    bus(1'b1, E1R_ADDR_CTRL, 32'h08);
    tx_stop <= 1'b1;
    repeat (940) @(posedge clk);
    check(loss_sync_or_tx_clock, 1'b0);
    repeat (160) @(posedge clk);
    check(loss_sync_or_tx_clock, 1'b1);
    tx_stop <= 1'b0;
    repeat (200) @(posedge clk);
    check(loss_sync_or_tx_clock, 1'b0);
    bus(1'b1, E1R_ADDR_CTRL, 32'h0);
    framer_mode_strap <= 1'b0;
    repeat (400) @(posedge clk);
    count_rises(2000, synth_output_clock, k);
    check(k >= 80 && k <= 84, 1'b1);
    sys_on <= 1'b1;
    bus(1'b1, E1R_ADDR_CTRL, 32'h04);
    check(rx_boundary_sync_oe, 1'b1);
    bus(1'b1, E1R_ADDR_CTRL, 32'h05);
    check(rx_boundary_sync_oe, 1'b0);
    repeat (9000) @(posedge clk);
    conclude();
  end
endmodule : e1r_rx_backplane_tb_top

/* File: e1r_rx_properties.sv */
// checker: pin timing relations of the e1 receive block
`timescale 1ns/1ps
module e1r_rx_properties
  import e1r_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_line_clock,
  input wire logic rx_system_clock,
  input wire logic framer_mode_strap,
  input wire logic rx_boundary_sync_oe,
  input wire logic receive_link_data,
  input wire logic receive_link_clock,
  input wire logic rx_channel_clock,
  input wire logic rx_serial_out,
  input wire logic rx_frame_pulse,
  input wire logic rx_multiframe_pulse,
  input wire logic rx_signaling_out,
  input wire logic loss_sync_or_tx_clock,
  input wire logic synth_output_clock
);
  // saturating ages; saturation makes the first event after reset pass
  logic [12:0] fr_cnt;
  logic [12:0] lk_cnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) fr_cnt <= '1;
    else if ($rose(rx_frame_pulse)) fr_cnt <= '0;
    else if (fr_cnt != '1) fr_cnt <= fr_cnt + 13'h1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) lk_cnt <= '1;
    else if ($changed(receive_link_clock)) lk_cnt <= '0;
    else if (lk_cnt != '1) lk_cnt <= lk_cnt + 13'h1;
  end
  // strobes last a whole system-clock period once the store runs, and
  // legacy pins only settle at the next tick after a strap change
  logic [7:0]  sys_age;
  logic [7:0]  strap_age;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sys_age <= '1;
    else if ($changed(rx_system_clock)) sys_age <= '0;
    else if (sys_age != '1) sys_age <= sys_age + 8'h01;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) strap_age <= '1;
    else if ($changed(framer_mode_strap)) strap_age <= '0;
    else if (strap_age != '1) strap_age <= strap_age + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_sync_dir_reset; $fell(reset) |-> rx_boundary_sync_oe; endproperty
  a_sync_dir_reset: assert property (p_sync_dir_reset) else $error("sync pin not output");
  property p_frame_width;
    $rose(rx_frame_pulse) && (sys_age == 8'hff) |-> rx_frame_pulse[*8] ##[1:12] !rx_frame_pulse;
  endproperty
  a_frame_width: assert property (p_frame_width) else $error("frame pulse width");
  // 256 bits of 16 clocks each
  property p_frame_spacing;
    $rose(rx_frame_pulse) && (sys_age == 8'hff) |-> fr_cnt >= 13'hffa;
  endproperty
  a_frame_spacing: assert property (p_frame_spacing) else $error("frame pulse early");
  property p_link_data_edge;
    $changed(receive_link_data) |-> rx_line_clock && $past(rx_line_clock, 2);
  endproperty
  a_link_data_edge: assert property (p_link_data_edge) else $error("link data off edge");
  property p_link_clock_rate; $changed(receive_link_clock) |-> lk_cnt >= 13'h333; endproperty
  a_link_clock_rate: assert property (p_link_clock_rate) else $error("link clock fast");
  property p_serial_edge;
    $changed(rx_serial_out) |-> (rx_line_clock && $past(rx_line_clock, 2))
      || (rx_system_clock && $past(rx_system_clock, 2));
  endproperty
  a_serial_edge: assert property (p_serial_edge) else $error("serial out off edge");
  property p_enh_quiet;
    !framer_mode_strap && (strap_age >= 8'd120) |-> !rx_channel_clock && !rx_multiframe_pulse
      && !loss_sync_or_tx_clock;
  endproperty
  a_enh_quiet: assert property (p_enh_quiet) else $error("legacy pin active");
  property p_legacy_quiet;
    framer_mode_strap && (strap_age >= 8'd120) |-> !synth_output_clock && !rx_signaling_out;
  endproperty
  a_legacy_quiet: assert property (p_legacy_quiet) else $error("enhanced pin active");
  property p_mf_on_frame; $rose(rx_multiframe_pulse) |-> ##[0:2] rx_frame_pulse; endproperty
  a_mf_on_frame: assert property (p_mf_on_frame) else $error("multiframe off frame");
  c_frame: cover property ($rose(rx_frame_pulse));
  c_mf: cover property ($rose(rx_multiframe_pulse));
  c_loss: cover property ($rose(loss_sync_or_tx_clock));
endmodule : e1r_rx_properties

bind e1r_rx_backplane e1r_rx_properties chk_u (
  .clk, .reset, .rx_line_clock, .rx_system_clock, .framer_mode_strap, .rx_boundary_sync_oe,
  .receive_link_data, .receive_link_clock, .rx_channel_clock, .rx_serial_out,
  .rx_frame_pulse, .rx_multiframe_pulse, .rx_signaling_out, .loss_sync_or_tx_clock,
  .synth_output_clock
);
